// *** include/epl_pkg.sv ***
// Purpose: Shared constants and types for the parallel port link
// Assumes: 125 MHz system clock
// Notes: Mode codes follow the extended control mode field
`default_nettype none
package epl_pkg;
    localparam int FIFO_DEPTH = 16;
    localparam int BYTE_W = 8;
    localparam int ENTRY_W = 9;
    localparam int MODE_W = 3;
    localparam int CTL_W = 4;
    localparam int STAT_W = 5;
    localparam logic [2:0] MODE_SPP = 3'h0;
    localparam logic [2:0] MODE_FIFO = 3'h2;
    localparam logic [2:0] MODE_ECP = 3'h3;
    localparam logic [2:0] MODE_TEST = 3'h6;
    localparam int CTL_STROBE = 0;
    localparam int CTL_AUTOFD = 1;
    localparam int CTL_INIT = 2;
    localparam int CTL_SELIN = 3;
    localparam int ADDR_BIT = 7;
    localparam logic [6:0] RLE_MAX = 7'h7f;
    localparam logic [6:0] RLE_NONE = 7'h00;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int STROBE_MIN_NS = 500;
    localparam int STROBE_CYC = (STROBE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    typedef enum logic [2:0] {F_IDLE, F_LOAD, F_EMIT, F_WAIT, F_STB, F_END} epl_fst_type;
    typedef enum logic [1:0] {R_IDLE, R_REQ, R_ACK, R_PUT} epl_rst_type;
endpackage
`default_nettype wire

// *** hdl/epl_fifo_mem.sv ***
// Purpose: Storage array for the shared byte FIFO
// Assumes: One write and one read port, read data registered
// Notes: Tag bit travels above the byte
`timescale 1ns/1ps
`default_nettype none
module epl_fifo_mem #(
    parameter int W = epl_pkg::ENTRY_W,
    parameter int D = epl_pkg::FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic wr_en,
    input wire logic [$clog2(D)-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [$clog2(D)-1:0] rd_addr,
    output logic [W-1:0] rd_data_ff
);
    logic [W-1:0] mem_ff [D];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem_ff[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rd_en) begin
            rd_data_ff <= mem_ff[rd_addr];
        end
    end
endmodule
`default_nettype wire

// *** hdl/epl_port.sv ***
// Purpose: Host end of an extended capabilities parallel port link
// Assumes: Pins sampled synchronously, control bits arrive as plain inputs
// Notes: One FIFO serves both directions
// Functional notes
// - Sixteen byte FIFO smooths forward and reverse data.
// - Reverse run length byte repeats the following byte in hardware.
// - Optional compression counts equal bytes, sends run length then byte.
// - No negotiation; automatic burst channel with DMA requests both ways.
// - Compatibility FIFO mode runs the strobe handshake in hardware.
// - Forward strobe latches data, interlocked with peripheral busy.
// - Reverse: autofeed low requests each byte, interlocked with ack.
// - Forward: autofeed tells address or command from data.
// - Init low selects reverse, high keeps forward.
// - Select-in stays deasserted throughout ECP mode.
// - Fault low in forward raises the error interrupt.
// - Plain printer port behaviour kept outside ECP mode.
// - ECP engine runs when mode field holds the ECP code.
// - All FIFO modes share one sixteen byte store.
`timescale 1ns/1ps
`default_nettype none
module epl_port #(
    parameter int DEPTH = epl_pkg::FIFO_DEPTH,
    parameter int STB_CYC = epl_pkg::STROBE_CYC
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [epl_pkg::MODE_W-1:0] mode,
    input wire logic dir_req,
    input wire logic compress_en,
    input wire logic dma_en,
    input wire logic [epl_pkg::CTL_W-1:0] spp_ctl,
    input wire logic [epl_pkg::BYTE_W-1:0] spp_data,
    input wire logic wr_valid,
    input wire logic [epl_pkg::BYTE_W-1:0] wr_data,
    input wire logic wr_cmd,
    output logic wr_ready_ff,
    output logic rd_valid_ff,
    output logic [epl_pkg::BYTE_W-1:0] rd_data_ff,
    output logic rd_cmd_ff,
    input wire logic rd_ready,
    output logic dma_req_ff,
    output logic err_irq_ff,
    output logic fifo_full_ff,
    output logic fifo_empty_ff,
    output logic [epl_pkg::STAT_W-1:0] status_ff,
    input wire logic [epl_pkg::BYTE_W-1:0] pd_in,
    output logic [epl_pkg::BYTE_W-1:0] pd_out_ff,
    output logic pd_oe_ff,
    output logic nstrobe_ff,
    output logic nautofd_ff,
    output logic ninit_ff,
    output logic nselectin_ff,
    input wire logic busy,
    input wire logic nack,
    input wire logic perror,
    input wire logic select,
    input wire logic nfault
);
    import epl_pkg::*;
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    function automatic logic has_room(input logic [CW-1:0] c);
        return c < CW'(DEPTH);
    endfunction

    logic [AW-1:0] wptr_ff, rptr_ff;
    logic [CW-1:0] count_ff, nxt_count;
    logic ecp, fifo_m, test_m, fwd_link;
    logic host_push, host_pop, link_push, link_pop, push, pop, rd_pend_ff, rev_ff;
    logic [ENTRY_W-1:0] push_data, mem_q;
    epl_fst_type fst_ff;
    epl_rst_type rst_ff;
    logic [BYTE_W-1:0] held_ff, pend_ff, tx_byte_ff, rbyte_ff;
    logic held_cmd_ff, pend_cmd_ff, held_v_ff, pend_v_ff, tx_cmd_ff, rle_sent_ff, rcmd_ff;
    logic [6:0] run_ff, rep_ff;
    logic [15:0] stb_cnt_ff;

    always_comb begin
        ecp = mode == MODE_ECP;
        fifo_m = mode == MODE_FIFO;
        test_m = mode == MODE_TEST;
        fwd_link = (ecp && !rev_ff && perror) || fifo_m;
        host_push = wr_valid && wr_ready_ff && has_room(count_ff);
        link_push = rst_ff == R_PUT && has_room(count_ff);
        push = host_push || link_push;
        push_data = link_push ? {rcmd_ff, rbyte_ff} : {wr_cmd, wr_data};
        link_pop = fst_ff == F_IDLE && fwd_link && count_ff != '0;
        host_pop = ((ecp && rev_ff) || test_m) && count_ff != '0 && !rd_valid_ff && !rd_pend_ff;
        pop = link_pop || host_pop;
        nxt_count = count_ff + CW'(push) - CW'(pop);
    end

    // One store for every FIFO mode
    epl_fifo_mem #(.W(ENTRY_W), .D(DEPTH)) u_mem (
        .sys_clk(sys_clk),
        .wr_en(push),
        .wr_addr(wptr_ff),
        .wr_data(push_data),
        .rd_en(pop),
        .rd_addr(rptr_ff),
        .rd_data_ff(mem_q)
    );

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
            count_ff <= '0;
        end else begin
            wptr_ff <= push ? wptr_ff + AW'(1) : wptr_ff;
            rptr_ff <= pop ? rptr_ff + AW'(1) : rptr_ff;
            count_ff <= nxt_count;
        end
    end

    // Host side of the FIFO and status
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            wr_ready_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            rd_valid_ff <= 1'b0;
            rd_data_ff <= '0;
            rd_cmd_ff <= 1'b0;
            fifo_full_ff <= 1'b0;
            fifo_empty_ff <= 1'b1;
            dma_req_ff <= 1'b0;
            err_irq_ff <= 1'b0;
            status_ff <= '0;
        end else begin
            wr_ready_ff <= (fifo_m || test_m || (ecp && !rev_ff)) && has_room(nxt_count);
            rd_pend_ff <= host_pop;
            if (rd_pend_ff) begin
                rd_valid_ff <= 1'b1;
                {rd_cmd_ff, rd_data_ff} <= mem_q;
            end else if (rd_ready) begin
                rd_valid_ff <= 1'b0;
            end
            fifo_full_ff <= nxt_count == CW'(DEPTH);
            fifo_empty_ff <= nxt_count == '0;
            dma_req_ff <= dma_en && ((((ecp && !rev_ff) || fifo_m) && has_room(nxt_count))
                || (ecp && rev_ff && nxt_count != '0));
            err_irq_ff <= ecp && !rev_ff && !nfault;
            status_ff <= {!busy, nack, perror, select, nfault};
        end
    end

    // Direction; forward drains before turning round
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rev_ff <= 1'b0;
        end else if (!ecp) begin
            rev_ff <= 1'b0;
        end else if (dir_req && fst_ff == F_IDLE && !held_v_ff && count_ff == '0) begin
            rev_ff <= 1'b1;
        end else if (!dir_req && rst_ff == R_IDLE) begin
            rev_ff <= 1'b0;
        end
    end

    // Forward engine with optional run compression
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            fst_ff <= F_IDLE;
            held_ff <= '0;
            held_cmd_ff <= 1'b0;
            held_v_ff <= 1'b0;
            pend_ff <= '0;
            pend_cmd_ff <= 1'b0;
            pend_v_ff <= 1'b0;
            run_ff <= RLE_NONE;
            rle_sent_ff <= 1'b0;
            tx_byte_ff <= '0;
            tx_cmd_ff <= 1'b0;
            stb_cnt_ff <= '0;
        end else begin
            unique case (fst_ff)
                F_IDLE: begin
                    if (link_pop) begin
                        fst_ff <= F_LOAD;
                    end else if (held_v_ff && fwd_link) begin
                        fst_ff <= F_EMIT;
                    end
                end
                F_LOAD: begin
                    if (compress_en && ecp && held_v_ff && !mem_q[BYTE_W] && !held_cmd_ff
                        && mem_q[BYTE_W-1:0] == held_ff && run_ff != RLE_MAX) begin
                        run_ff <= run_ff + 7'h01;
                        fst_ff <= F_IDLE;
                    end else if (held_v_ff) begin
                        {pend_cmd_ff, pend_ff} <= mem_q;
                        pend_v_ff <= 1'b1;
                        fst_ff <= F_EMIT;
                    end else begin
                        {held_cmd_ff, held_ff} <= mem_q;
                        held_v_ff <= 1'b1;
                        run_ff <= RLE_NONE;
                        fst_ff <= (compress_en && ecp) ? F_IDLE : F_EMIT;
                    end
                end
                F_EMIT: begin
                    if (run_ff != RLE_NONE && !rle_sent_ff) begin
                        tx_byte_ff <= {1'b0, run_ff};
                        tx_cmd_ff <= 1'b1;
                        rle_sent_ff <= 1'b1;
                    end else begin
                        tx_byte_ff <= held_ff;
                        tx_cmd_ff <= held_cmd_ff && ecp;
                        held_ff <= pend_ff;
                        held_cmd_ff <= pend_cmd_ff;
                        held_v_ff <= pend_v_ff;
                        pend_v_ff <= 1'b0;
                        run_ff <= RLE_NONE;
                        rle_sent_ff <= 1'b0;
                    end
                    fst_ff <= F_WAIT;
                end
                F_WAIT: begin
                    if (!busy) begin
                        stb_cnt_ff <= 16'(STB_CYC - 1);
                        fst_ff <= F_STB;
                    end
                end
                F_STB: begin
                    stb_cnt_ff <= stb_cnt_ff - 16'h0001;
                    if (ecp ? busy : stb_cnt_ff == '0) begin
                        fst_ff <= F_END;
                    end
                end
                F_END: begin
                    fst_ff <= (held_v_ff && (rle_sent_ff || !(compress_en && ecp))) ? F_EMIT
                        : F_IDLE;
                end
                default: fst_ff <= F_IDLE;
            endcase
        end
    end

    // Reverse engine with run length expansion
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rst_ff <= R_IDLE;
            rbyte_ff <= '0;
            rcmd_ff <= 1'b0;
            rep_ff <= RLE_NONE;
        end else begin
            unique case (rst_ff)
                R_IDLE: begin
                    if (ecp && rev_ff && dir_req && !perror && has_room(count_ff)) begin
                        rst_ff <= R_REQ;
                    end
                end
                R_REQ: begin
                    if (!nack) begin
                        rbyte_ff <= pd_in;
                        rcmd_ff <= !busy;
                        rst_ff <= R_ACK;
                    end else if (!dir_req) begin
                        rst_ff <= R_IDLE; // Host withdraws an unanswered request
                    end
                end
                R_ACK: begin
                    if (nack) begin
                        if (rcmd_ff && !rbyte_ff[ADDR_BIT]) begin
                            rep_ff <= rbyte_ff[6:0];
                            rst_ff <= R_IDLE;
                        end else begin
                            rst_ff <= R_PUT;
                        end
                    end
                end
                R_PUT: begin
                    if (link_push) begin
                        if (rcmd_ff || rep_ff == RLE_NONE) begin
                            rst_ff <= R_IDLE;
                        end else begin
                            rep_ff <= rep_ff - 7'h01;
                        end
                    end
                end
            endcase
        end
    end

    // Pin drivers
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pd_out_ff <= '0;
            pd_oe_ff <= 1'b1;
            nstrobe_ff <= 1'b1;
            nautofd_ff <= 1'b1;
            ninit_ff <= 1'b1;
            nselectin_ff <= 1'b1;
        end else if (ecp) begin
            pd_out_ff <= tx_byte_ff;
            pd_oe_ff <= !rev_ff && perror;
            nstrobe_ff <= fst_ff != F_STB;
            nautofd_ff <= rev_ff ? rst_ff != R_REQ : !tx_cmd_ff;
            ninit_ff <= !rev_ff;
            nselectin_ff <= 1'b1;
        end else begin
            pd_out_ff <= fifo_m ? tx_byte_ff : spp_data;
            pd_oe_ff <= fifo_m || mode == MODE_SPP || !dir_req;
            nstrobe_ff <= fifo_m ? fst_ff != F_STB : !spp_ctl[CTL_STROBE];
            nautofd_ff <= !spp_ctl[CTL_AUTOFD];
            ninit_ff <= spp_ctl[CTL_INIT];
            nselectin_ff <= !spp_ctl[CTL_SELIN];
        end
    end

    property p_fifo_full;
        @(posedge sys_clk) disable iff (!nrst) push |-> count_ff < CW'(DEPTH);
    endproperty
    a_fifo_full: assert property (p_fifo_full) else $error("push into full fifo");

    property p_rle_rep;
        @(posedge sys_clk) disable iff (!nrst)
            (rst_ff == R_PUT && link_push && !rcmd_ff && rep_ff != RLE_NONE)
            |=> rst_ff == R_PUT && rep_ff == $past(rep_ff) - 7'h01;
    endproperty
    a_rle_rep: assert property (p_rle_rep) else $error("run repeat miscounted");

    property p_dma;
        @(posedge sys_clk) disable iff (!nrst) dma_req_ff |-> $past(dma_en);
    endproperty
    a_dma: assert property (p_dma) else $error("dma request without enable");

    property p_strobe_busy;
        @(posedge sys_clk) disable iff (!nrst)
            $fell(nstrobe_ff) && ($past(mode, 2) == MODE_ECP || $past(mode, 2) == MODE_FIFO)
            |-> !$past(busy, 2);
    endproperty
    a_strobe_busy: assert property (p_strobe_busy) else $error("strobe while busy");

    property p_ack_release;
        @(posedge sys_clk) disable iff (!nrst)
            (rst_ff == R_REQ && !nack && ecp) |=> rst_ff == R_ACK ##1 nautofd_ff;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("autofeed held");

    property p_hostack_cmd;
        @(posedge sys_clk) disable iff (!nrst)
            !nstrobe_ff && $past(ecp) |-> nautofd_ff == !tx_cmd_ff;
    endproperty
    a_hostack_cmd: assert property (p_hostack_cmd) else $error("hostack wrong");

    property p_init_dir;
        @(posedge sys_clk) disable iff (!nrst) ecp |=> ninit_ff == !$past(rev_ff);
    endproperty
    a_init_dir: assert property (p_init_dir) else $error("init not direction");

    property p_no_drive;
        @(posedge sys_clk) disable iff (!nrst) ecp && (!perror || rev_ff) |=> !pd_oe_ff;
    endproperty
    a_no_drive: assert property (p_no_drive) else $error("bus driven unacked");

    property p_selin;
        @(posedge sys_clk) disable iff (!nrst) ecp |=> nselectin_ff;
    endproperty
    a_selin: assert property (p_selin) else $error("select-in asserted");

    property p_err_irq;
        @(posedge sys_clk) disable iff (!nrst)
            ecp && !rev_ff && !nfault |=> err_irq_ff ##0 !status_ff[0];
    endproperty
    a_err_irq: assert property (p_err_irq) else $error("fault not raised");

    property p_reset;
        @(posedge sys_clk) !nrst |=> nstrobe_ff && nautofd_ff && ninit_ff && pd_oe_ff && !rev_ff;
    endproperty
    a_reset: assert property (p_reset) else $error("bad reset state");

    c_fwd_byte: cover property (@(posedge sys_clk) disable iff (!nrst) fst_ff == F_STB && ecp);
    c_rev_byte: cover property (@(posedge sys_clk) disable iff (!nrst) link_push);
    c_rle_out: cover property (@(posedge sys_clk) disable iff (!nrst) rle_sent_ff);
    c_full: cover property (@(posedge sys_clk) disable iff (!nrst) fifo_full_ff);
endmodule
`default_nettype wire

// *** tb/epl_periph_model.sv ***
// Purpose: Behavioural far-end peripheral for the parallel port link
// Assumes: Pins sampled on the system clock, select tied on line
// Notes: Released data lines show the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module epl_periph_model (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic stall,
    input wire logic fault_hint,
    input wire logic [epl_pkg::BYTE_W-1:0] pd_bus,
    input wire logic nstrobe,
    input wire logic nautofd,
    input wire logic ninit,
    input wire logic nselectin,
    output logic [epl_pkg::BYTE_W-1:0] pd_drive,
    output logic busy,
    output logic nack,
    output logic perror,
    output logic nfault,
    output logic select
);
    import epl_pkg::*;
    logic [8:0] fwd_q[$];
    logic [8:0] rev_q[$];
    logic [7:0] last_pd;
    logic rev_phase;
    logic driving;
    assign select = 1'b1;
    assign nfault = ~fault_hint;
    assign driving = !ninit && !perror && !nautofd && nselectin && rev_phase;
    assign pd_drive = driving ? last_pd : ~last_pd;
    always @(posedge sys_clk) begin
        if (!nrst) begin
            busy <= 1'b0;
            nack <= 1'b1;
            perror <= 1'b1;
            rev_phase <= 1'b0;
            last_pd <= 8'h00;
        end else if (ninit) begin
            perror <= 1'b1;
            nack <= 1'b1;
            rev_phase <= 1'b0;
            if (!nstrobe && !busy) begin
                fwd_q.push_back({~nautofd, pd_bus});
                busy <= 1'b1;
            end else if (nstrobe && busy && !stall) begin
                busy <= 1'b0;
            end
        end else begin
            perror <= 1'b0;
            if (!perror && !nautofd && nack && rev_q.size() > 0) begin
                if (!rev_phase) begin
                    last_pd <= rev_q[0][7:0];
                    busy <= ~rev_q[0][8];
                    rev_phase <= 1'b1;
                end else begin
                    nack <= 1'b0;
                end
            end else if (nautofd && !nack) begin
                nack <= 1'b1;
                rev_phase <= 1'b0;
                void'(rev_q.pop_front());
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/ecp_parallel_port_link_test.sv ***
// Purpose: Self-checking bench for the parallel port link
// Assumes: Strobe width shortened to four cycles
// Notes: Inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module ecp_parallel_port_link_test;
    import epl_pkg::*;
    logic sys_clk, nrst, dir_req, compress_en, dma_en, wr_valid, wr_cmd, rd_ready;
    logic stall, fault_hint, wr_ready_ff, rd_valid_ff, rd_cmd_ff, dma_req_ff, err_irq_ff;
    logic fifo_full_ff, fifo_empty_ff, pd_oe_ff, nstrobe_ff, nautofd_ff, ninit_ff;
    logic nselectin_ff, busy, nack, perror, select, nfault;
    logic [2:0] mode;
    logic [3:0] spp_ctl;
    logic [7:0] spp_data, wr_data, pd_in, pd_drive, rd_data_ff, pd_out_ff;
    logic [4:0] status_ff;
    int num_errors = 0;
    int comparisons = 0;
    assign pd_in = pd_oe_ff ? pd_out_ff : pd_drive;
    epl_port #(.DEPTH(FIFO_DEPTH), .STB_CYC(4)) uut (
        .sys_clk(sys_clk), .nrst(nrst), .mode(mode), .dir_req(dir_req),
        .compress_en(compress_en), .dma_en(dma_en), .spp_ctl(spp_ctl), .spp_data(spp_data),
        .wr_valid(wr_valid), .wr_data(wr_data), .wr_cmd(wr_cmd), .wr_ready_ff(wr_ready_ff),
        .rd_valid_ff(rd_valid_ff), .rd_data_ff(rd_data_ff), .rd_cmd_ff(rd_cmd_ff),
        .rd_ready(rd_ready), .dma_req_ff(dma_req_ff), .err_irq_ff(err_irq_ff),
        .fifo_full_ff(fifo_full_ff), .fifo_empty_ff(fifo_empty_ff), .status_ff(status_ff),
        .pd_in(pd_in), .pd_out_ff(pd_out_ff), .pd_oe_ff(pd_oe_ff), .nstrobe_ff(nstrobe_ff),
        .nautofd_ff(nautofd_ff), .ninit_ff(ninit_ff), .nselectin_ff(nselectin_ff),
        .busy(busy), .nack(nack), .perror(perror), .select(select), .nfault(nfault)
    );
    epl_periph_model periph (
        .sys_clk(sys_clk), .nrst(nrst), .stall(stall), .fault_hint(fault_hint),
        .pd_bus(pd_in), .nstrobe(nstrobe_ff), .nautofd(nautofd_ff), .ninit(ninit_ff),
        .nselectin(nselectin_ff), .pd_drive(pd_drive), .busy(busy), .nack(nack),
        .perror(perror), .nfault(nfault), .select(select)
    );
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_byte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic wrap_up();
        if (num_errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic host_write(input logic [7:0] b, input logic c, output logic ok);
        wr_valid = 1'b1;
        wr_data = b;
        wr_cmd = c;
        ok = 1'b0;
        for (int i = 0; i < 8 && !ok; i++) begin
            ok = wr_ready_ff;
            @(negedge sys_clk);
        end
        if (!ok)
            wr_valid = 1'b0;
    endtask
    task automatic host_read(input logic [7:0] b, input logic c);
        for (int i = 0; i < 300 && rd_valid_ff !== 1'b1; i++) @(negedge sys_clk);
        check_bit(rd_valid_ff, 1'b1);
        check_byte(rd_data_ff, b);
        check_bit(rd_cmd_ff, c);
        rd_ready = 1'b1;
        @(negedge sys_clk);
        rd_ready = 1'b0;
    endtask
    task automatic t_reset();
        check_bit(pd_oe_ff, 1'b1);
        check_byte({4'h0, nstrobe_ff, nautofd_ff, ninit_ff, nselectin_ff}, 8'h0f);
        check_bit(fifo_empty_ff, 1'b1);
    endtask
    task automatic t_spp();
        spp_ctl = 4'h5;
        spp_data = 8'h3c;
        repeat (3) @(negedge sys_clk);
        check_byte({4'h0, nstrobe_ff, nautofd_ff, ninit_ff, nselectin_ff}, 8'h07);
        check_byte(pd_out_ff, 8'h3c);
        spp_ctl = 4'ha;
        repeat (3) @(negedge sys_clk);
        check_byte({4'h0, nstrobe_ff, nautofd_ff, ninit_ff, nselectin_ff}, 8'h08);
        spp_ctl = 4'h4;
        repeat (4) @(negedge sys_clk);
    endtask
    task automatic t_ecp_fwd();
        logic ok;
        mode = MODE_ECP;
        periph.fwd_q.delete();
        host_write(8'h81, 1'b1, ok);
        host_write(8'h5a, 1'b0, ok);
        host_write(8'h00, 1'b0, ok);
        wr_valid = 1'b0;
        for (int i = 0; i < 400 && periph.fwd_q.size() < 3; i++) @(negedge sys_clk);
        check_byte(periph.fwd_q[0][7:0], 8'h81);
        check_bit(periph.fwd_q[0][8], 1'b1);
        check_byte(periph.fwd_q[1][7:0], 8'h5a);
        check_bit(periph.fwd_q[1][8], 1'b0);
        check_byte(periph.fwd_q[2][7:0], 8'h00);
        dma_en = 1'b1;
        repeat (4) @(negedge sys_clk);
        check_bit(dma_req_ff, 1'b1);
        dma_en = 1'b0;
        repeat (3) @(negedge sys_clk);
        check_bit(dma_req_ff, 1'b0);
        fault_hint = 1'b1;
        repeat (3) @(negedge sys_clk);
        check_bit(err_irq_ff, 1'b1);
        check_byte({3'h0, status_ff}, 8'h1e);
        fault_hint = 1'b0;
        repeat (3) @(negedge sys_clk);
        check_bit(err_irq_ff, 1'b0);
        compress_en = 1'b1;
        for (int k = 0; k < 3; k++) host_write(8'h33, 1'b0, ok);
        wr_valid = 1'b0;
        for (int i = 0; i < 400 && periph.fwd_q.size() < 5; i++) @(negedge sys_clk);
        check_bit(periph.fwd_q.size() == 5, 1'b1);
        check_byte(periph.fwd_q[3][7:0], 8'h02);
        check_bit(periph.fwd_q[3][8], 1'b1);
        check_byte(periph.fwd_q[4][7:0], 8'h33);
        compress_en = 1'b0;
    endtask
    task automatic t_compat_fill();
        logic ok;
        int n;
        mode = MODE_FIFO;
        stall = 1'b1;
        periph.fwd_q.delete();
        n = 0;
        ok = 1'b1;
        while (ok && n < 20) begin
            host_write(8'h40 + n[7:0], 1'b0, ok);
            if (ok)
                n++;
        end
        check_bit(fifo_full_ff, 1'b1);
        check_bit(wr_ready_ff, 1'b0);
        check_bit(n >= 16 && n <= 18, 1'b1);
        stall = 1'b0;
        for (int i = 0; i < 3000 && periph.fwd_q.size() < n; i++) @(negedge sys_clk);
        check_bit(periph.fwd_q.size() == n, 1'b1);
        for (int j = 0; j < n; j++) check_byte(periph.fwd_q[j][7:0], 8'h40 + j[7:0]);
        repeat (20) @(negedge sys_clk);
        check_bit(fifo_empty_ff, 1'b1);
    endtask
    task automatic t_reverse();
        mode = MODE_ECP;
        periph.rev_q = '{9'h102, 9'h0a5, 9'h185, 9'h011};
        dir_req = 1'b1;
        for (int i = 0; i < 50 && ninit_ff !== 1'b0; i++) @(negedge sys_clk);
        check_bit(ninit_ff, 1'b0);
        fault_hint = 1'b1;
        repeat (3) @(negedge sys_clk);
        check_bit(pd_oe_ff, 1'b0);
        check_bit(err_irq_ff, 1'b0);
        fault_hint = 1'b0;
        for (int k = 0; k < 3; k++) host_read(8'ha5, 1'b0);
        host_read(8'h85, 1'b1);
        host_read(8'h11, 1'b0);
        check_bit(periph.rev_q.size() == 0, 1'b1);
        dir_req = 1'b0;
        for (int i = 0; i < 50 && ninit_ff !== 1'b1; i++) @(negedge sys_clk);
        repeat (4) @(negedge sys_clk);
        check_bit(ninit_ff, 1'b1);
        check_bit(pd_oe_ff, 1'b1);
    endtask
    task automatic t_test_fifo();
        logic ok;
        mode = MODE_TEST;
        host_write(8'h6c, 1'b0, ok);
        wr_valid = 1'b0;
        host_read(8'h6c, 1'b0);
        repeat (3) @(negedge sys_clk);
        check_bit(fifo_empty_ff, 1'b1);
    endtask
    always @(negedge sys_clk)
        if (nrst && mode == MODE_ECP) check_bit(nselectin_ff, 1'b1);
    initial begin
        #100000;
        num_errors++;
        wrap_up();
    end
    initial begin
        nrst = 1'b0;
        mode = MODE_SPP;
        {dir_req, compress_en, dma_en, wr_valid, wr_cmd, rd_ready, stall, fault_hint} = 8'h00;
        spp_ctl = 4'h4;
        spp_data = 8'h00;
        wr_data = 8'h00;
        repeat (5) @(negedge sys_clk);
        t_reset();
        nrst = 1'b1;
        t_spp();
        t_ecp_fwd();
        t_compat_fill();
        t_reverse();
        t_test_fifo();
        wrap_up();
    end
endmodule
`default_nettype wire
